// ---- rtl/diag_event_pkg.sv ----
// Shared constants and carrier types for the diagnostic event logic
package diag_event_pkg;

    // ==========================================================
    // Sizes
    localparam int CHANNELS = 16;
    localparam int CH_EVENTS = 11;
    localparam int MOD_EVENTS = 24;
    localparam int CODE_W = 10;
    localparam int CFG_W = 5;

    // ==========================================================
    // Fault codes per module event index, lowest index wins arbitration
    localparam logic [CODE_W-1:0] MOD_CODE [MOD_EVENTS] = '{
        10'h005, 10'h010, 10'h011, 10'h040, 10'h041, 10'h042,
        10'h043, 10'h044, 10'h045, 10'h046, 10'h047, 10'h049,
        10'h04A, 10'h04B, 10'h04C, 10'h04D, 10'h04E, 10'h100,
        10'h103, 10'h11B, 10'h30D, 10'h312, 10'h321, 10'h322};
    // Module event indices of the supply voltage faults
    localparam int MOD_IDX_SUPPLY_HIGH = 22;
    localparam int MOD_IDX_SUPPLY_LOW = 23;

    // Fault codes per channel event index
    localparam logic [CODE_W-1:0] CH_CODE [CH_EVENTS] = '{
        10'h300, 10'h301, 10'h302, 10'h303, 10'h305, 10'h306,
        10'h307, 10'h30B, 10'h310, 10'h311, 10'h31C};
    localparam logic [CODE_W-1:0] DISC_CODE_BASE = 10'h300;
    localparam logic [CODE_W-1:0] CODE_MAX = 10'h322;
    localparam logic [CODE_W-1:0] CH_CODE_FIRST = 10'h300;

    // ==========================================================
    // Application class filters and configurable events
    localparam logic [CH_EVENTS-1:0] CH_CLASS1_MASK = 11'h7F0;
    localparam logic [CH_EVENTS-1:0] CH_CLASS23_MASK = 11'h0FF;
    localparam logic [MOD_EVENTS-1:0] MOD_CLASS1_MASK = 24'hFF_FFFF;
    localparam logic [MOD_EVENTS-1:0] MOD_CLASS23_MASK = 24'h1F_FFFF;
    // Channel event index gated by each configuration enable bit
    localparam int CFG_EVENT_IDX [CFG_W] = '{5, 6, 7, 8, 10};

    // ==========================================================
    // Indicator flash timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000
        / CLK_PERIOD_NS;
    localparam logic [31:0] BLINK_RESET = 32'h0000_0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic input_short_p;
        logic freq_high;
        logic flutter;
        logic fail_ack;
        logic overload;
        logic short_p;
        logic unclear;
        logic disc_fail;
        logic [1:0] disc_pair;
    } chan_fault_type;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic module_scope;
        logic [3:0] channel;
    } irq_record_type;

    typedef struct packed {
        logic [CHANNELS-1:0] status;
        logic [CHANNELS-1:0] diag;
        logic run;
        logic error;
    } led_type;

endpackage

// ---- rtl/event_latch.sv ----
// Edge detector with sticky pending bits for a group of fault levels
`timescale 1ns/10ps
module event_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] arm,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] pending
);

    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] pending_q;
    logic [WIDTH-1:0] rise;

    // Previous level for onset detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_q <= '0;
        else
            prev_q <= level;
    end

    assign rise = level & ~prev_q;

    // one pending alarm per onset
    // A set in the clearing cycle wins, so no onset is lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pending_q <= '0;
        else
            pending_q <= (pending_q & ~clear) | (rise & arm);
    end

    assign pending = pending_q;

    chk_onset_latched: assert property (
        @(posedge clk) disable iff (rst)
        |(rise & arm) |=> ((pending_q & $past(rise & arm))
            == $past(rise & arm)))
        else $error("armed onset was not latched");

    chk_unarmed_no_set: assert property (
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pending_q & ~$past(pending_q) & ~$past(arm)) == '0))
        else $error("suppressed event became pending");

endmodule

// ---- rtl/blink_gen.sv ----
// Free running square wave for flashing indicators
`timescale 1ns/10ps
module blink_gen #(
    parameter int HALF_CYCLES = diag_event_pkg::FLASH_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic blink
);

    logic [31:0] count_q;
    logic blink_q;

    // Half period counter, toggles the phase on wrap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= diag_event_pkg::BLINK_RESET;
            blink_q <= 1'b0;
        end
        else if (count_q >= 32'(HALF_CYCLES - 1))
        begin
            count_q <= diag_event_pkg::BLINK_RESET;
            blink_q <= ~blink_q;
        end
        else
            count_q <= count_q + 32'h0000_0001;
    end

    assign blink = blink_q;

endmodule

// ---- rtl/safety_input_diag_events.sv ----
// Diagnostic interrupt source and supply fault indicator logic
`timescale 1ns/10ps
module safety_input_diag_events #(
    parameter int FLASH_HALF = diag_event_pkg::FLASH_HALF_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] CH_IN,
    input wire diag_event_pkg::chan_fault_type [15:0] CH_FAULT,
    input wire logic [23:0] MOD_FAULT,
    input wire logic NEW_HOST,
    input wire logic [1:0] APP_CLASS,
    input wire logic [4:0] CFG_ENABLE,
    input wire logic USER_ACK,
    input wire logic IRQ_READY,
    output logic IRQ_VALID,
    output diag_event_pkg::irq_record_type IRQ,
    output logic PASSIVATED,
    output diag_event_pkg::led_type LEDS
);

    localparam int NCH = diag_event_pkg::CHANNELS;
    localparam int NE = diag_event_pkg::CH_EVENTS;
    localparam int NM = diag_event_pkg::MOD_EVENTS;

    typedef enum {RUNNING, SUPPLY_FAULT, WAIT_ACK} pass_state_type;

    // ==========================================================
    // Input synchronisers
    logic [15:0] ch_in_m_q;
    logic [15:0] ch_in_s_q;
    diag_event_pkg::chan_fault_type [15:0] ch_fault_m_q;
    diag_event_pkg::chan_fault_type [15:0] ch_fault_s_q;
    logic [NM-1:0] mod_fault_m_q;
    logic [NM-1:0] mod_fault_s_q;
    logic new_host_m_q;
    logic new_host_s_q;

    // Pins are asynchronous; only the second stage is read below
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ch_in_m_q <= '0;
            ch_in_s_q <= '0;
            ch_fault_m_q <= '0;
            ch_fault_s_q <= '0;
            mod_fault_m_q <= '0;
            mod_fault_s_q <= '0;
            new_host_m_q <= 1'b0;
            new_host_s_q <= 1'b0;
        end
        else
        begin
            ch_in_m_q <= CH_IN;
            ch_in_s_q <= ch_in_m_q;
            ch_fault_m_q <= CH_FAULT;
            ch_fault_s_q <= ch_fault_m_q;
            mod_fault_m_q <= MOD_FAULT;
            mod_fault_s_q <= mod_fault_m_q;
            new_host_m_q <= NEW_HOST;
            new_host_s_q <= new_host_m_q;
        end
    end

    // ==========================================================
    // Event arming by application class and configuration
    logic [NE-1:0] ch_arm;
    logic [NM-1:0] mod_arm;
    logic [NE-1:0] cfg_mask;

    // 775 and 779 follow their enables, 785 never does
    always_comb
    begin
        cfg_mask = '1;
        for (int k = 0; k < diag_event_pkg::CFG_W; k++)
            cfg_mask[diag_event_pkg::CFG_EVENT_IDX[k]] = CFG_ENABLE[k];
    end

    // discrepancy only in classes 2 and 3
    // class 1 only codes; class 0 reports nothing
    always_comb
    begin
        case (APP_CLASS)
            2'h1:
            begin
                ch_arm = diag_event_pkg::CH_CLASS1_MASK & cfg_mask;
                mod_arm = diag_event_pkg::MOD_CLASS1_MASK;
            end
            2'h2, 2'h3:
            begin
                ch_arm = diag_event_pkg::CH_CLASS23_MASK & cfg_mask;
                mod_arm = diag_event_pkg::MOD_CLASS23_MASK;
            end
            default:
            begin
                ch_arm = '0;
                mod_arm = '0;
            end
        endcase
    end

    // ==========================================================
    // Event latches, one per channel and one for the module
    logic [NE-1:0] ch_level [NCH];
    logic [NE-1:0] ch_pend [NCH];
    logic [NE-1:0] ch_clr [NCH];
    logic [NM-1:0] mod_pend;
    logic [NM-1:0] mod_clr;

    // pair state selects one of four consecutive codes
    // unclear signal is a channel event in classes 1, 2 and 3
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            ch_level[c][0] = ch_fault_s_q[c].disc_fail
                && ch_fault_s_q[c].disc_pair == 2'h0;
            ch_level[c][1] = ch_fault_s_q[c].disc_fail
                && ch_fault_s_q[c].disc_pair == 2'h1;
            ch_level[c][2] = ch_fault_s_q[c].disc_fail
                && ch_fault_s_q[c].disc_pair == 2'h2;
            ch_level[c][3] = ch_fault_s_q[c].disc_fail
                && ch_fault_s_q[c].disc_pair == 2'h3;
            ch_level[c][4] = ch_fault_s_q[c].unclear;
            ch_level[c][5] = ch_fault_s_q[c].short_p;
            ch_level[c][6] = ch_fault_s_q[c].overload;
            ch_level[c][7] = ch_fault_s_q[c].fail_ack;
            ch_level[c][8] = ch_fault_s_q[c].flutter;
            ch_level[c][9] = ch_fault_s_q[c].freq_high;
            ch_level[c][10] = ch_fault_s_q[c].input_short_p;
        end
    end

    for (genvar c = 0; c < NCH; c++)
    begin : g_chan
        event_latch #(.WIDTH(NE)) u_latch (
            .clk(CLK),
            .rst(RST),
            .level(ch_level[c]),
            .arm(ch_arm),
            .clear(ch_clr[c]),
            .pending(ch_pend[c])
        );
    end

    event_latch #(.WIDTH(NM)) u_mod_latch (
        .clk(CLK),
        .rst(RST),
        .level(mod_fault_s_q),
        .arm(mod_arm),
        .clear(mod_clr),
        .pending(mod_pend)
    );

    // ==========================================================
    // Arbitration: module events first, then channels by index
    logic found;
    diag_event_pkg::irq_record_type sel;
    logic load;
    logic irq_valid_q;
    diag_event_pkg::irq_record_type irq_q;

    assign load = !irq_valid_q || IRQ_READY;

    // scope and channel follow the winning event
    always_comb
    begin
        found = 1'b0;
        sel = '0;
        mod_clr = '0;
        for (int c = 0; c < NCH; c++)
            ch_clr[c] = '0;
        for (int m = 0; m < NM; m++)
        begin
            if (!found && mod_pend[m])
            begin
                found = 1'b1;
                sel.code = diag_event_pkg::MOD_CODE[m];
                sel.module_scope = 1'b1;
                mod_clr[m] = load;
            end
        end
        for (int c = 0; c < NCH; c++)
        begin
            for (int e = 0; e < NE; e++)
            begin
                if (!found && ch_pend[c][e])
                begin
                    found = 1'b1;
                    sel.code = diag_event_pkg::CH_CODE[e];
                    sel.channel = 4'(c);
                    ch_clr[c][e] = load;
                end
            end
        end
    end

    // record held until the controller takes it
    // ten bit code field carries every code unshortened
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            irq_valid_q <= 1'b0;
            irq_q <= '0;
        end
        else if (load)
        begin
            irq_valid_q <= found;
            irq_q <= sel;
        end
    end

    assign IRQ_VALID = irq_valid_q;
    assign IRQ = irq_q;

    // ==========================================================
    // Passivation after supply voltage faults
    pass_state_type state_q;
    logic supply_bad;

    assign supply_bad = mod_fault_s_q[diag_event_pkg::MOD_IDX_SUPPLY_HIGH]
        || mod_fault_s_q[diag_event_pkg::MOD_IDX_SUPPLY_LOW];

    // older host returns on its own once the supply recovers
    // An acknowledgment while the fault persists is ignored
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_q <= RUNNING;
        else
        begin
            case (state_q)
                RUNNING:
                    if (supply_bad)
                        state_q <= SUPPLY_FAULT;
                SUPPLY_FAULT:
                    if (!supply_bad)
                        state_q <= new_host_s_q ? WAIT_ACK : RUNNING;
                WAIT_ACK:
                    if (supply_bad)
                        state_q <= SUPPLY_FAULT;
                    else if (USER_ACK)
                        state_q <= RUNNING;
                default:
                    state_q <= RUNNING;
            endcase
        end
    end

    assign PASSIVATED = state_q != RUNNING;

    // ==========================================================
    // Indicators
    logic blink;
    diag_event_pkg::led_type leds_q;
    logic [NCH-1:0] ch_diag;

    blink_gen #(.HALF_CYCLES(FLASH_HALF)) u_blink (
        .clk(CLK),
        .rst(RST),
        .blink(blink)
    );

    // Channel diagnostic lamp while any event of that channel is pending
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
            ch_diag[c] = |ch_pend[c];
    end

    // supply pattern overrides the normal display
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            leds_q <= '0;
        else if (state_q != RUNNING)
        begin
            leds_q.status <= '0;
            leds_q.diag <= '1;
            leds_q.run <= 1'b1;
            leds_q.error <= blink;
        end
        else
        begin
            leds_q.status <= ch_in_s_q & ~ch_diag;
            leds_q.diag <= ch_diag;
            leds_q.run <= 1'b1;
            leds_q.error <= irq_valid_q && blink;
        end
    end

    assign LEDS = leds_q;

    // ==========================================================
    // Checks
    sequence supply_gone;
        !supply_bad && state_q == SUPPLY_FAULT;
    endsequence

    chk_supply_pattern: assert property (
        @(posedge CLK) disable iff (RST)
        state_q != RUNNING |=> leds_q.status == '0 && &leds_q.diag
            && leds_q.run && leds_q.error == $past(blink))
        else $error("supply fault indicator pattern wrong");

    chk_ack_hold: assert property (
        @(posedge CLK) disable iff (RST)
        supply_gone ##1 (state_q == WAIT_ACK && !USER_ACK && !supply_bad)
            |=> state_q == WAIT_ACK)
        else $error("left passivation without acknowledgment");

    chk_auto_return: assert property (
        @(posedge CLK) disable iff (RST)
        supply_gone and !new_host_s_q |=> state_q == RUNNING)
        else $error("older host mode did not reintegrate");

    chk_supply_enter: assert property (
        @(posedge CLK) disable iff (RST)
        supply_bad |=> PASSIVATED)
        else $error("supply fault did not passivate");

    chk_irq_hold: assert property (
        @(posedge CLK) disable iff (RST)
        irq_valid_q && !IRQ_READY |=> irq_valid_q && $stable(irq_q))
        else $error("pending interrupt changed before taken");

    chk_irq_scope: assert property (
        @(posedge CLK) disable iff (RST)
        irq_valid_q && irq_q.code < diag_event_pkg::CH_CODE_FIRST
            |-> irq_q.module_scope && irq_q.channel == 4'h0)
        else $error("low code not module scoped");

    chk_code_range: assert property (
        @(posedge CLK) disable iff (RST)
        irq_valid_q |-> irq_q.code <= diag_event_pkg::CODE_MAX
            && irq_q.code != '0)
        else $error("interrupt code out of range");

    chk_disc_code: assert property (
        @(posedge CLK) disable iff (RST)
        load && found && !sel.module_scope
            && sel.code < diag_event_pkg::CH_CODE[4]
            |-> ch_pend[sel.channel][sel.code[1:0]]
            && sel.code[9:2] == diag_event_pkg::DISC_CODE_BASE[9:2])
        else $error("discrepancy code does not match pair");

endmodule

// ---- verification/diag_host_model.sv ----
// Behavioural safety controller that collects diagnostic records
`timescale 1ns/10ps
module diag_host_model (
    input wire logic clk,
    input wire logic irq_valid,
    input wire diag_event_pkg::irq_record_type irq,
    input wire logic stall,
    input wire logic ack_req,
    output logic irq_ready,
    output logic user_ack
);
    // ==========================================================
    // Collected records, oldest first
    diag_event_pkg::irq_record_type rx_q[$];
    logic ack_seen;

    // Quiet start so nothing is taken before the bench asks
    initial
    begin
        irq_ready = 1'b0;
        user_ack = 1'b0;
        ack_seen = 1'b0;
    end

    // Ready and ack change just after the edge by non-blocking update,
    // so bench controls set at the falling edge never race this model
    always @(posedge clk)
    begin
        irq_ready <= !stall;
        user_ack <= ack_req && !ack_seen; // One pulse per request
        ack_seen <= ack_req;
    end

    // A record is taken only where ready meets valid
    always @(posedge clk)
    begin
        if (irq_valid === 1'b1 && irq_ready === 1'b1)
            rx_q.push_back(irq);
    end
endmodule

// ---- verification/tb_safety_input_diag_events.sv ----
// Self-checking bench for the diagnostic event logic
`timescale 1ns/10ps
module tb_safety_input_diag_events;
    // ==========================================================
    // Stimulus and observation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] ch_in = 16'h0000;
    diag_event_pkg::chan_fault_type [15:0] ch_fault = '0;
    logic [23:0] mod_fault = 24'h00_0000;
    logic new_host = 1'b0;
    logic [1:0] app_class = 2'h1;
    logic [4:0] cfg_enable = 5'h1F;
    logic stall = 1'b0;
    logic ack_req = 1'b0;
    logic user_ack;
    logic irq_ready;
    logic irq_valid;
    diag_event_pkg::irq_record_type irq;
    logic passivated;
    diag_event_pkg::led_type leds;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Expected codes worked out by hand, not read from the design
    logic [9:0] mod_exp [24] = '{10'h005, 10'h010, 10'h011, 10'h040,
        10'h041, 10'h042, 10'h043, 10'h044, 10'h045, 10'h046, 10'h047,
        10'h049, 10'h04A, 10'h04B, 10'h04C, 10'h04D, 10'h04E, 10'h100,
        10'h103, 10'h11B, 10'h30D, 10'h312, 10'h321, 10'h322};
    logic [9:0] ch_exp [11] = '{10'h300, 10'h301, 10'h302, 10'h303,
        10'h305, 10'h306, 10'h307, 10'h30B, 10'h310, 10'h311, 10'h31C};
    logic [9:0] ch_val [11] = '{10'h004, 10'h005, 10'h006, 10'h007,
        10'h008, 10'h010, 10'h020, 10'h040, 10'h080, 10'h100, 10'h200};

    // Short flash period keeps the run brief
    always #5 clk = ~clk;

    safety_input_diag_events #(.FLASH_HALF(4)) dut_u (
        .CLK(clk), .RST(rst), .CH_IN(ch_in), .CH_FAULT(ch_fault),
        .MOD_FAULT(mod_fault), .NEW_HOST(new_host),
        .APP_CLASS(app_class), .CFG_ENABLE(cfg_enable),
        .USER_ACK(user_ack), .IRQ_READY(irq_ready),
        .IRQ_VALID(irq_valid), .IRQ(irq), .PASSIVATED(passivated),
        .LEDS(leds));

    diag_host_model host_u (
        .clk(clk), .irq_valid(irq_valid), .irq(irq), .stall(stall),
        .ack_req(ack_req), .irq_ready(irq_ready), .user_ack(user_ack));

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait for the next record, then compare it whole
    task automatic expect_rec(input logic [9:0] code, input logic scope,
        input logic [3:0] ch);
        int n;
        diag_event_pkg::irq_record_type r;
        n = 0;
        while (host_u.rx_q.size() == 0 && n < 40)
        begin
            tick(1);
            n++;
        end
        r = '1;
        if (host_u.rx_q.size() != 0)
            r = host_u.rx_q.pop_front();
        check(r, {code, scope, ch});
    endtask

    // Silence check: a dropped onset must not surface within 20 cycles
    task automatic expect_none();
        tick(20);
        check(host_u.rx_q.size(), 0);
        host_u.rx_q.delete();
    endtask

    // Raise one channel event, judge, then let it fall
    task automatic ch_event(input int ch, input int i, input logic hit);
        ch_fault[ch] = diag_event_pkg::chan_fault_type'(ch_val[i]);
        if (hit)
            expect_rec(ch_exp[i], 1'b0, ch[3:0]);
        else
            expect_none();
        ch_fault[ch] = '0;
        tick(6);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check({irq_valid, passivated, leds}, 0);
        rst = 1'b0;
        ch_in = 16'h00A5;
        tick(5);
        check(leds.status, 16'h00A5);
        check(leds.run, 1);
        $display("test reset done");
    endtask

    task automatic test_module_codes();
        app_class = 2'h1;
        for (int i = 0; i < 24; i++)
        begin
            mod_fault[i] = 1'b1;
            expect_rec(mod_exp[i], 1'b1, 4'h0);
            mod_fault[i] = 1'b0;
            tick(8);
        end
        $display("test module codes done");
    endtask

    task automatic test_channel_codes();
        app_class = 2'h2;
        for (int i = 0; i < 8; i++)
            ch_event(5, i, 1'b1);
        app_class = 2'h1;
        for (int i = 4; i < 11; i++)
            ch_event(12, i, 1'b1);
        $display("test channel codes done");
    endtask

    task automatic test_filters();
        cfg_enable = 5'h00;
        for (int i = 5; i < 11; i++)
            ch_event(3, i, i == 9);
        cfg_enable = 5'h1F;
        ch_event(3, 0, 1'b0);
        app_class = 2'h2;
        ch_event(3, 8, 1'b0);
        // Address storage fault reported in class 2, undertemperature not
        mod_fault[20] = 1'b1;
        expect_rec(10'h30D, 1'b1, 4'h0);
        mod_fault[20] = 1'b0;
        mod_fault[21] = 1'b1;
        expect_none();
        mod_fault[21] = 1'b0;
        tick(6);
        app_class = 2'h3;
        ch_event(3, 3, 1'b1);
        app_class = 2'h0;
        // class 0 reports nothing at all
        ch_event(3, 4, 1'b0);
        $display("test filters done");
    endtask

    task automatic test_priority();
        app_class = 2'h1;
        stall = 1'b1;
        mod_fault[1:0] = 2'h3;
        ch_fault[3] = diag_event_pkg::chan_fault_type'(10'h008);
        tick(10);
        check(irq_valid, 1);
        check(irq.code, 10'h005);
        check(leds.diag, 16'h0008);
        stall = 1'b0;
        expect_rec(10'h005, 1'b1, 4'h0);
        expect_rec(10'h010, 1'b1, 4'h0);
        expect_rec(10'h305, 1'b0, 4'h3);
        mod_fault[1:0] = 2'h0;
        ch_fault[3] = '0;
        tick(8);
        $display("test priority done");
    endtask

    task automatic test_supply_new_host();
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        app_class = 2'h2;
        new_host = 1'b1;
        tick(4);
        mod_fault[23] = 1'b1;
        tick(4);
        check(passivated, 1);
        tick(1);
        check(leds.status, 16'h0000);
        check(leds.diag, 16'hFFFF);
        check(leds.run, 1);
        repeat (12)
        begin
            tick(1);
            if (leds.error === 1'b1)
                hi++;
            if (leds.error === 1'b0)
                lo++;
        end
        check(hi > 0 && lo > 0, 1);
        mod_fault[23] = 1'b0;
        tick(12);
        check(passivated, 1);
        expect_none();
        ack_req = 1'b1;
        tick(4);
        check(passivated, 0);
        ack_req = 1'b0;
        tick(2);
        check(leds.status, 16'h00A5);
        $display("test supply new host done");
    endtask

    task automatic test_supply_old_host();
        app_class = 2'h1;
        new_host = 1'b0;
        tick(4);
        mod_fault[22] = 1'b1;
        tick(5);
        check(passivated, 1);
        expect_rec(10'h321, 1'b1, 4'h0);
        mod_fault[22] = 1'b0;
        tick(5);
        check(passivated, 0);
        $display("test supply old host done");
    endtask

    // ==========================================================
    // Verdict, reached from the main flow or the hang guard
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard well beyond the fewer than a thousand cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("BAD at %0t: timeout", $time);
            conclude();
        end
    end

    // Main sequence
    initial
    begin
        tick(6);
        test_reset();
        test_module_codes();
        test_channel_codes();
        test_filters();
        test_priority();
        test_supply_new_host();
        test_supply_old_host();
        conclude();
    end
endmodule
